// File: logic/scw_pkg.sv
// Shared constants and carriers for the SPI challenge watchdog.
// Assumes a 20 MHz ref_clk and an APB master on the same clock.
package scw_pkg;
	localparam int CLK_HZ        = 20_000_000; // Core clock rate
	localparam int WD_PERIOD_MS  = 256;        // Default period
	localparam int WD_PERIOD_CYC = CLK_HZ / 1000 * WD_PERIOD_MS;
	localparam int RST_PULSE_US  = 1000;       // Reset pulse length
	localparam int RST_PULSE_CYC = CLK_HZ / 1_000_000 * RST_PULSE_US;

	// Frame codes
	localparam logic [15:0] REFRESH_WORD = 16'h5A00; // Plain refresh
	localparam logic [15:0] CHAL_RD_CMD  = 16'h1B00; // Challenge read
	localparam logic [7:0]  REFRESH_WORD_8     = 8'h1A;    // Short refresh
	localparam logic [4:0]  FRAME_SHORT  = 5'h08;    // 8-bit frame
	localparam logic [4:0]  FRAME_LONG   = 5'h10;    // 16-bit frame
	localparam logic [7:0]  SLICE2_MASK  = 8'hC0;    // Top 2-bit slice

	// Challenge generator
	localparam logic [7:0] LFSR_SEED = 8'hA5; // Nonzero start
	localparam logic [7:0] LFSR_TAPS = 8'hB8; // Maximal length

	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	// Control fields
	localparam int CTRL_RT_LSB  = 0; // refresh_type_sel, 2 bits
	localparam int CTRL_WIN_BIT = 2; // window_timeout_sel
	localparam int CTRL_SAFE_BIT = 3; // safe_delay_sel
	localparam int CTRL_PAR_BIT = 4; // Parity check enable

	// Refresh variants
	typedef enum logic [1:0] {
		RT_SIMPLE = 2'b00,
		RT_ADV1   = 2'b01,
		RT_ADV2   = 2'b10,
		RT_ADV4   = 2'b11
	} scw_rtype_t;

	// Supervisor states, one-hot
	typedef enum logic [2:0] {
		ST_INIT   = 3'b001,
		ST_NORMAL = 3'b010,
		ST_RESET  = 3'b100
	} scw_state_t;

	// APB request and answer
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} scw_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} scw_apb_rsp_t;

	// SPI pins from the host
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} scw_spi_in_t;
endpackage

// File: logic/scw_lfsr.sv
// Free-running 8-bit challenge source.
// Assumes the reader samples it only on a frame event.
`timescale 1ns/1ps
module scw_lfsr #(
	parameter logic [7:0] SEED = scw_pkg::LFSR_SEED,
	parameter logic [7:0] TAPS = scw_pkg::LFSR_TAPS
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	output logic [7:0]      code
);
	import scw_pkg::*;
	typedef struct packed {
		logic [7:0] v; // Shift state
	} scw_lfsr_t;
	scw_lfsr_t q_r, q_nxt;

	// Galois step, never reaches zero
	always_comb begin
		q_nxt = q_r;
		q_nxt.v = {1'b0, q_r.v[7:1]} ^ (q_r.v[0] ? TAPS : 8'h00);
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q_r <= '{v: SEED};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign code = q_r.v;
endmodule // scw_lfsr

// File: logic/scw_spi_port.sv
// SPI slave framer, mode 0, MSB first, 8 or 16 bit frames.
// Assumes pins are asynchronous; all are synchronised here.
`timescale 1ns/1ps
module scw_spi_port (
	input  wire logic            ref_clk,
	input  wire logic            nrst,
	input  scw_pkg::scw_spi_in_t spi_i,
	input  wire logic [7:0]      flags,
	input  wire logic [7:0]      resp,
	output logic                 miso,
	output logic                 miso_oe,
	output logic                 byte1_pulse,
	output logic [7:0]           rx_byte,
	output logic                 frame_pulse,
	output logic [15:0]          frame_word,
	output logic [4:0]           frame_bits
);
	import scw_pkg::*;
	typedef struct packed {
		logic [1:0]  sclk_s; // Sync stages
		logic [1:0]  cs_s;
		logic [1:0]  mosi_s;
		logic        sclk_d; // Edge history
		logic        cs_d;
		logic [15:0] rx;     // Receive shifter
		logic [7:0]  tx;     // Transmit shifter
		logic [4:0]  cnt;    // Bits seen
		logic        miso;
		logic        oe;
		logic        b1;
		logic        done;
		logic [15:0] word;
		logic [4:0]  bits;
	} scw_spi_t;
	scw_spi_t q_r, q_nxt;
	logic rise, fall, act;

	// Edge finding and shifting
	always_comb begin
		q_nxt = q_r;
		q_nxt.sclk_s = {q_r.sclk_s[0], spi_i.sclk};
		q_nxt.cs_s = {q_r.cs_s[0], spi_i.cs_n};
		q_nxt.mosi_s = {q_r.mosi_s[0], spi_i.mosi};
		q_nxt.sclk_d = q_r.sclk_s[1];
		q_nxt.cs_d = q_r.cs_s[1];
		q_nxt.b1 = 1'b0;
		q_nxt.done = 1'b0;
		rise = q_r.sclk_s[1] & ~q_r.sclk_d;
		fall = ~q_r.sclk_s[1] & q_r.sclk_d;
		act = ~q_r.cs_s[1];
		if (q_r.cs_d && act) begin
			// Frame start: global flags first
			q_nxt.cnt = 5'h00;
			q_nxt.tx = flags;
			q_nxt.miso = flags[7];
			q_nxt.oe = 1'b1;
		end else if (!q_r.cs_d && !act) begin
			// Frame end: hand the word over
			q_nxt.done = 1'b1;
			q_nxt.word = q_r.rx;
			q_nxt.bits = q_r.cnt;
			q_nxt.oe = 1'b0;
		end else if (act && rise) begin
			q_nxt.rx = {q_r.rx[14:0], q_r.mosi_s[1]};
			if (q_r.cnt != FRAME_LONG + 5'h01) begin
				q_nxt.cnt = q_r.cnt + 5'h01;
			end
			q_nxt.b1 = (q_r.cnt == FRAME_SHORT - 5'h01);
		end else if (act && fall) begin
			if (q_r.cnt == FRAME_SHORT) begin
				// Second byte comes from the supervisor
				q_nxt.tx = resp;
				q_nxt.miso = resp[7];
			end else begin
				q_nxt.tx = {q_r.tx[6:0], 1'b0};
				q_nxt.miso = q_r.tx[6];
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q_r <= '{sclk_s: 2'b00, cs_s: 2'b11, mosi_s: 2'b00,
				cs_d: 1'b1, default: '0};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign miso = q_r.miso;
	assign miso_oe = q_r.oe;
	assign byte1_pulse = q_r.b1;
	assign rx_byte = q_r.rx[7:0];
	assign frame_pulse = q_r.done;
	assign frame_word = q_r.word;
	assign frame_bits = q_r.bits;
endmodule // scw_spi_port

// File: logic/scw_top.sv
// Watchdog supervisor refreshed over SPI, set up over APB.
// Assumes APB on ref_clk and a host SPI master on the pins.
`timescale 1ns/1ps
// Operation
// - Timeout, window and challenge supervision variants
// - One plain refresh word enters Normal
// - Timeout: refresh accepted anywhere in period
// - Window: refresh only in second half
// - Read command returns challenge in byte two
// - Single mode returns new challenge each refresh
// - Window plus single answer must be open
// - Second part returns next challenge
// - Only final part needs open window
// - Fourth part returns next challenge
// - Short read frame refreshes in simple mode only, returns flags
// - Safe delay: safe only on second reset
// - Two-bit field selects refresh variant
// - Select bit picks timeout or window
// - Missing or bad refresh forces reset
module scw_top #(
	parameter int WD_PERIOD_CYC_P = scw_pkg::WD_PERIOD_CYC,
	parameter int RST_PULSE_CYC_P = scw_pkg::RST_PULSE_CYC
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  scw_pkg::scw_apb_req_t apb_i,
	output scw_pkg::scw_apb_rsp_t apb_o,
	input  scw_pkg::scw_spi_in_t  spi_i,
	input  wire logic [7:0]       status_flags,
	input  wire logic [7:0]       status_ext,
	output logic                  miso,
	output logic                  miso_oe,
	output logic                  wd_rst_n,
	output logic                  safe_n,
	output logic                  normal_mode
);
	import scw_pkg::*;

	// All supervisor state
	typedef struct packed {
		scw_state_t  st;      // Supervisor state
		scw_rtype_t  rtype;   // refresh_type_sel
		logic        win;     // window_timeout_sel
		logic        sdly;    // safe_delay_sel
		logic        par_en;  // Parity check enable
		logic [31:0] period;  // Period in cycles
		logic [31:0] tmr;     // Time into period
		logic [1:0]  part;    // Accepted partial answers
		logic [7:0]  code;    // challenge_code in force
		logic [7:0]  pend;    // Code sent on MISO
		logic [7:0]  resp;    // Second MISO byte
		logic [1:0]  consec;  // Consecutive watchdog resets
		logic [31:0] rcnt;    // Reset pulse timer
		logic        rst_n;   // Reset output
		logic        safe_n;  // Safe output
		logic        normal;  // Normal mode flag
		scw_apb_rsp_t apb;    // Bus answer
	} scw_top_t;
	scw_top_t q_r, q_nxt;

	logic [7:0]  lfsr_code;  // Fresh challenge source
	logic        b1_pulse;   // First byte received
	logic [7:0]  rx_byte;    // First byte value
	logic        fr_pulse;   // Frame complete
	logic [15:0] fr_word;    // Frame content
	logic [4:0]  fr_bits;    // Frame length
	logic        hdr16;      // Watchdog write header
	logic        par_ok;     // Bit 8 check
	logic        last_part;  // Final partial answer
	logic        open_win;   // Second half of period
	logic        time_ok;    // Timing accepted
	logic        is_r8;      // Short refresh frame
	logic        good;       // Full refresh accepted
	logic        bad;        // Fault seen
	logic [1:0]  last_idx;   // Index of last partial
	logic [7:0]  expect_lo;  // Expected low byte
	logic [7:0]  inv;        // Inverted challenge
	logic        addr_ok;    // Mapped address

	// SPI framing
	scw_spi_port u_spi (
		.ref_clk     (ref_clk),
		.nrst        (nrst),
		.spi_i       (spi_i),
		.flags       (status_flags),
		.resp        (q_r.resp),
		.miso        (miso),
		.miso_oe     (miso_oe),
		.byte1_pulse (b1_pulse),
		.rx_byte     (rx_byte),
		.frame_pulse (fr_pulse),
		.frame_word  (fr_word),
		.frame_bits  (fr_bits)
	);

	// Challenge generator
	scw_lfsr u_lfsr (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.code    (lfsr_code)
	);

	// Frame checks
	always_comb begin
		inv = ~q_r.code;
		unique case (q_r.rtype)
			RT_ADV2: last_idx = 2'd1;
			RT_ADV4: last_idx = 2'd3;
			default: last_idx = 2'd0; // Simple and single
		endcase
		unique case (q_r.rtype)
			RT_SIMPLE: expect_lo = 8'h00;
			RT_ADV1: expect_lo = inv;
			RT_ADV2: expect_lo = q_r.part[0] ?
				{4'h0, inv[3:0]} : {inv[7:4], 4'h0};
			RT_ADV4: expect_lo = inv &
				(SLICE2_MASK >> {q_r.part, 1'b0});
		endcase
		hdr16 = (fr_bits == FRAME_LONG) &&
			(fr_word[15:9] == REFRESH_WORD[15:9]);
		par_ok = q_r.par_en ?
			(fr_word[8] == ^{fr_word[15:9], fr_word[7:0]}) :
			~fr_word[8];
		last_part = (q_r.part == last_idx);
		open_win = (q_r.tmr >= (q_r.period >> 1));
		time_ok = ~q_r.win | ~last_part | open_win;
		is_r8 = (fr_bits == FRAME_SHORT) &&
			(fr_word[7:0] == REFRESH_WORD_8);
	end

	// Supervisor, SPI answers and register bus
	always_comb begin
		q_nxt = q_r;
		good = 1'b0;
		bad = 1'b0;
		addr_ok = 1'b0;
		// Second MISO byte picked after first byte
		if (b1_pulse) begin
			if (rx_byte[7:1] == REFRESH_WORD[15:9] &&
				q_r.st == ST_NORMAL &&
				q_r.rtype != RT_SIMPLE && last_part) begin
				q_nxt.resp = lfsr_code;
				q_nxt.pend = lfsr_code;
			end else if (rx_byte == CHAL_RD_CMD[15:8]) begin
				q_nxt.resp = q_r.code;
			end else begin
				q_nxt.resp = status_ext;
			end
		end
		unique case (q_r.st)
			ST_INIT: begin
				// Single plain refresh enters Normal
				if (fr_pulse && hdr16 && par_ok &&
					fr_word[7:0] == REFRESH_WORD[7:0]) begin
					q_nxt.st = ST_NORMAL;
					q_nxt.normal = 1'b1;
					q_nxt.tmr = 32'h0000_0000;
					q_nxt.part = 2'd0;
					q_nxt.code = lfsr_code;
				end
			end
			ST_NORMAL: begin
				q_nxt.tmr = q_r.tmr + 32'h0000_0001;
				if (fr_pulse && hdr16) begin
					if (par_ok && fr_word[7:0] == expect_lo &&
						time_ok) begin
						if (last_part) begin
							good = 1'b1;
						end else begin
							q_nxt.part = q_r.part + 2'd1;
						end
					end else begin
						bad = 1'b1;
					end
				end else if (fr_pulse && is_r8 &&
					q_r.rtype == RT_SIMPLE) begin
					// Short frame obeys the same window
					if (time_ok) begin
						good = 1'b1;
					end else begin
						bad = 1'b1;
					end
				end else if (q_r.tmr >= q_r.period - 32'h0000_0001) begin
					bad = 1'b1;
				end
				if (good) begin
					q_nxt.tmr = 32'h0000_0000;
					q_nxt.part = 2'd0;
					q_nxt.consec = 2'd0;
					if (q_r.rtype != RT_SIMPLE) begin
						q_nxt.code = q_r.pend;
					end
				end
				if (bad) begin
					// Enter reset, count consecutive ones
					q_nxt.st = ST_RESET;
					q_nxt.normal = 1'b0;
					q_nxt.part = 2'd0;
					q_nxt.rcnt = 32'h0000_0000;
					q_nxt.rst_n = 1'b0;
					if (q_r.consec != 2'd2) begin
						q_nxt.consec = q_r.consec + 2'd1;
					end
					if (!q_r.sdly || q_r.consec != 2'd0) begin
						q_nxt.safe_n = 1'b0;
					end
				end
			end
			ST_RESET: begin
				// Hold reset for the pulse length
				q_nxt.rcnt = q_r.rcnt + 32'h0000_0001;
				if (q_r.rcnt >= 32'(RST_PULSE_CYC_P - 1)) begin
					q_nxt.st = ST_INIT;
					q_nxt.rst_n = 1'b1;
				end
			end
		endcase

		// APB: answer one cycle after setup
		addr_ok = (apb_i.paddr == ADDR_CTRL) ||
			(apb_i.paddr == ADDR_PERIOD) ||
			(apb_i.paddr == ADDR_STATUS);
		q_nxt.apb.pready = 1'b0;
		q_nxt.apb.pslverr = 1'b0;
		if (apb_i.psel && !apb_i.penable && !q_r.apb.pready) begin
			q_nxt.apb.pready = 1'b1;
			q_nxt.apb.pslverr = ~addr_ok;
			q_nxt.apb.prdata = 32'h0000_0000;
			if (!apb_i.pwrite) begin
				unique case (apb_i.paddr)
					ADDR_CTRL: q_nxt.apb.prdata = 32'({q_r.par_en,
						q_r.sdly, q_r.win, q_r.rtype});
					ADDR_PERIOD: q_nxt.apb.prdata = q_r.period;
					ADDR_STATUS: q_nxt.apb.prdata = 32'({q_r.consec,
						~q_r.safe_n, ~q_r.rst_n, q_r.part, q_r.st});
					default: q_nxt.apb.prdata = 32'h0000_0000;
				endcase
			end
		end
		// Write lands at the completing edge
		if (apb_i.psel && apb_i.penable && q_r.apb.pready &&
			apb_i.pwrite && !q_r.apb.pslverr) begin
			if (apb_i.paddr == ADDR_CTRL) begin
				q_nxt.rtype = scw_rtype_t'(
					apb_i.pwdata[CTRL_RT_LSB +: 2]);
				q_nxt.win = apb_i.pwdata[CTRL_WIN_BIT];
				q_nxt.sdly = apb_i.pwdata[CTRL_SAFE_BIT];
				q_nxt.par_en = apb_i.pwdata[CTRL_PAR_BIT];
			end else if (apb_i.paddr == ADDR_PERIOD) begin
				q_nxt.period = apb_i.pwdata;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q_r <= '{st: ST_INIT, rtype: RT_SIMPLE,
				period: 32'(WD_PERIOD_CYC_P),
				rst_n: 1'b1, safe_n: 1'b1, default: '0};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign apb_o = q_r.apb;
	assign wd_rst_n = q_r.rst_n;
	assign safe_n = q_r.safe_n;
	assign normal_mode = q_r.normal;
endmodule // scw_top

// File: tb/scw_asserts.sv
// Port-level checker for the SPI challenge watchdog.
// Assumes it is bound onto scw_top with the same pulse length.
`timescale 1ns/1ps
module scw_asserts #(
	parameter int RST_PULSE_CYC_P = 50
) (
	input wire logic             ref_clk,
	input wire logic             nrst,
	input scw_pkg::scw_apb_req_t apb_i,
	input scw_pkg::scw_apb_rsp_t apb_o,
	input scw_pkg::scw_spi_in_t  spi_i,
	input wire logic             miso_oe,
	input wire logic             wd_rst_n,
	input wire logic             safe_n,
	input wire logic             normal_mode
);
	import scw_pkg::*;
	int lo_cnt; // Cycles of the current reset pulse
	// Length of the watchdog reset pulse
	always_ff @(posedge ref_clk) begin
		if (!nrst || wd_rst_n) lo_cnt <= 0;
		else lo_cnt <= lo_cnt + 1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Bus phases
	sequence s_setup;
		apb_i.psel && !apb_i.penable && !apb_o.pready;
	endsequence
	sequence s_access;
		apb_i.psel && apb_i.penable && apb_o.pready;
	endsequence
	property p_ready; s_setup |=> s_access ##1 !apb_o.pready; endproperty
	a_ready: assert property (p_ready) else $error("no one-cycle answer");
	property p_noreq;
		$rose(apb_o.pready) |-> $past(apb_i.psel && !apb_i.penable);
	endproperty
	a_noreq: assert property (p_noreq) else $error("answer without setup");
	property p_err; apb_o.pslverr |-> apb_o.pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_enter;
		$rose(normal_mode) |-> $past(spi_i.cs_n, 2) && !$past(spi_i.cs_n, 10);
	endproperty
	a_enter: assert property (p_enter) else $error("entry without frame");
	property p_plen;
		$rose(wd_rst_n) |-> lo_cnt inside {[RST_PULSE_CYC_P - 1 :
			RST_PULSE_CYC_P + 1]};
	endproperty
	a_plen: assert property (p_plen) else $error("reset pulse length");
	property p_rstoff; !wd_rst_n && !$past(wd_rst_n) |-> !normal_mode; endproperty
	a_rstoff: assert property (p_rstoff) else $error("normal in reset");
	property p_nfall; $fell(normal_mode) |-> ##[0:1] !wd_rst_n; endproperty
	a_nfall: assert property (p_nfall) else $error("normal left silently");
	property p_safe; $fell(safe_n) |-> ##[0:2] !wd_rst_n; endproperty
	a_safe: assert property (p_safe) else $error("safe without reset");
	property p_stick; !safe_n |=> !safe_n; endproperty
	a_stick: assert property (p_stick) else $error("safe released");
	property p_oe; spi_i.cs_n [*6] |-> !miso_oe; endproperty
	a_oe: assert property (p_oe) else $error("miso driven idle");
endmodule // scw_asserts

bind scw_top scw_asserts #(.RST_PULSE_CYC_P(RST_PULSE_CYC_P)) chk_u (
	.ref_clk(ref_clk), .nrst(nrst), .apb_i(apb_i), .apb_o(apb_o),
	.spi_i(spi_i), .miso_oe(miso_oe), .wd_rst_n(wd_rst_n),
	.safe_n(safe_n), .normal_mode(normal_mode));

// File: tb/scw_host_model.sv
// Host SPI master model, mode 0, MSB first, 400 ns sclk.
// Assumes a 50 ns ref_clk; frames are started by task call.
`timescale 1ns/1ps
module scw_host_model (
	input  wire logic            ref_clk,
	input  wire logic            miso,
	input  wire logic            miso_oe,
	output scw_pkg::scw_spi_in_t spi_o
);
	import scw_pkg::*;
	// Deselected, clock parked low between frames
	initial spi_o = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
	// One frame of n bits taken from the low end of w
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = '0;
		@(posedge ref_clk) spi_o.cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_o.mosi <= w[i];
			repeat (4) @(posedge ref_clk);
			spi_o.sclk <= 1'b1;
			repeat (2) @(posedge ref_clk);
			// Undriven line reads as the inverse of the last bit
			r = {r[14:0], miso_oe ? miso : ~r[0]};
			repeat (2) @(posedge ref_clk);
			spi_o.sclk <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		spi_o.cs_n <= 1'b1;
		spi_o.mosi <= ~spi_o.mosi; // Released, no hold
		repeat (8) @(posedge ref_clk);
	endtask
endmodule // scw_host_model

// File: tb/test_scw_top.sv
// Self-checking bench for the SPI challenge watchdog.
// Assumes scw_host_model on the SPI pins and APB from here.
`timescale 1ns/1ps
module test_scw_top;
	import scw_pkg::*;
	localparam int PER = 2000; // Shortened period
	localparam int PLS = 50;   // Shortened reset pulse
	logic         ref_clk, nrst, miso, miso_oe, wd_rst_n, safe_n, nm;
	scw_apb_req_t apb_i;
	scw_apb_rsp_t apb_o;
	scw_spi_in_t  spi_i;
	logic [7:0]   flags, ext, code, nc;
	logic [15:0]  rx;
	int           bad_count, samples_checked, cyc;
	scw_top #(.WD_PERIOD_CYC_P(PER), .RST_PULSE_CYC_P(PLS)) dut_u (
		.ref_clk(ref_clk), .nrst(nrst), .apb_i(apb_i), .apb_o(apb_o),
		.spi_i(spi_i), .status_flags(flags), .status_ext(ext),
		.miso(miso), .miso_oe(miso_oe), .wd_rst_n(wd_rst_n),
		.safe_n(safe_n), .normal_mode(nm));
	scw_host_model host_u (.ref_clk(ref_clk), .miso(miso),
		.miso_oe(miso_oe), .spi_o(spi_i));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("mismatches %0d of %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic er);
		int n;
		n = 0;
		@(posedge ref_clk);
		apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk);
		apb_i.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (apb_o.pready !== 1'b1 && n < 50);
		r = apb_o.prdata;
		er = apb_o.pslverr;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        er;
		apb(1'b1, a, d, r, er);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] r;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, r, er);
		chk(e, r & m);
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask
	// Wait for a watchdog reset, or its absence, then the pulse end
	task automatic exp_rst(input int lim, input logic e);
		int n;
		n = 0;
		while (wd_rst_n !== 1'b0 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk({31'h0, e}, {31'h0, wd_rst_n === 1'b0});
		if (e) repeat (PLS + 10) @(posedge ref_clk);
	endtask
	task automatic go_normal();
		host_u.xfer(REFRESH_WORD, 16, rx);
		chk(32'h1, {31'h0, nm});
	endtask
	// Challenge answer in np parts, the last one late when windowed
	task automatic refresh(input logic [7:0] c, input int np,
		input logic win, input int stop);
		int          w;
		logic [7:0]  m;
		w = 8 / np;
		for (int i = 0; i < stop; i++) begin
			m = 8'(((1 << w) - 1) << (8 - w * (i + 1)));
			if (win && i == np - 1) repeat (1100) @(posedge ref_clk);
			host_u.xfer({8'h5A, ~c & m}, 16, rx);
			if (i < np - 1) chk({24'h0, ext}, {24'h0, rx[7:0]});
		end
		nc = rx[7:0];
	endtask
	task automatic t_regs();
		logic [31:0] r;
		logic        er;
		rdc(ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
		rdc(ADDR_PERIOD, PER, 32'hFFFF_FFFF);
		rdc(ADDR_STATUS, 32'h0000_0001, 32'hFFFF_FFFF);
		wr(ADDR_CTRL, 32'h0000_001F);
		rdc(ADDR_CTRL, 32'h0000_001F, 32'hFFFF_FFFF);
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_STATUS, 32'hFFFF_FFFF);
		rdc(ADDR_STATUS, 32'h0000_0001, 32'h0000_0007);
		apb(1'b0, 8'h0C, 32'h0000_0000, r, er);
		chk({31'h0, er}, 32'h1);
	endtask
	task automatic t_timeout();
		go_normal();
		host_u.xfer(REFRESH_WORD, 16, rx);
		repeat (2) begin
			exp_rst(1200, 1'b0);
			host_u.xfer({8'h00, REFRESH_WORD_8}, 8, rx);
			chk(flags, rx[7:0]);
		end
		exp_rst(PER + 200, 1'b1);
		chk(32'h0, {31'h0, safe_n});
		rdc(ADDR_STATUS, 32'h0000_0001, 32'h0000_0007);
	endtask
	task automatic t_window();
		do_reset();
		wr(ADDR_CTRL, 32'h1 << CTRL_WIN_BIT);
		go_normal();
		repeat (1100) @(posedge ref_clk);
		host_u.xfer(REFRESH_WORD, 16, rx);
		exp_rst(20, 1'b0);
		host_u.xfer(REFRESH_WORD, 16, rx);
		exp_rst(50, 1'b1);
	endtask
	task automatic t_adv(input scw_rtype_t rt, input logic win);
		int np;
		np = 1 << (rt - 1);
		do_reset();
		wr(ADDR_CTRL, {win, rt});
		go_normal();
		host_u.xfer(CHAL_RD_CMD, 16, rx);
		code = rx[7:0];
		repeat (2) begin
			refresh(code, np, win, np);
			chk(32'h1, {31'h0, nm && nc != code});
			code = nc;
		end
		refresh(~code, np, win, 1);
		exp_rst(50, 1'b1);
	endtask
	// Parity on: a refresh with a wrong bit 8 forces reset
	task automatic t_parity();
		do_reset();
		wr(ADDR_CTRL, 32'h1 << CTRL_PAR_BIT);
		go_normal();
		host_u.xfer(16'h5B00, 16, rx);
		exp_rst(50, 1'b1);
	endtask
	task automatic t_safe();
		do_reset();
		wr(ADDR_CTRL, 32'h1 << CTRL_SAFE_BIT);
		go_normal();
		exp_rst(PER + 200, 1'b1);
		chk(32'h1, {31'h0, safe_n});
		go_normal();
		exp_rst(PER + 200, 1'b1);
		chk(32'h0, {31'h0, safe_n});
	endtask
	// Main sequence
	initial begin
		nrst = 1'b0;
		apb_i = '0;
		flags = 8'h5C;
		ext = 8'h3E;
		bad_count = 0;
		samples_checked = 0;
		cyc = 0;
		@(posedge ref_clk);
		do_reset();
		t_regs();
		t_timeout();
		t_window();
		t_adv(RT_ADV1, 1'b0);
		t_adv(RT_ADV2, 1'b0);
		t_adv(RT_ADV4, 1'b1);
		t_parity();
		t_safe();
		complete_run();
	end
endmodule // test_scw_top
